// ==== rtl/rrs_pkg.sv ====
package rrs_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned RST_MIN_LOW_NS  = 2000;
    localparam int unsigned RST_MIN_LOW_CYC =
        (RST_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Release-delay timers
    // ------------------------------------------------------------
    localparam logic [7:0] T3_PRESET     = 8'hFF;
    localparam logic [7:0] T4_PRESET     = 8'h07;
    localparam logic [3:0] PRESCALE_LAST = 4'hF;  // divide by 16
    localparam logic [7:0] T_ZERO        = 8'h00;

    // ------------------------------------------------------------
    // Reset vector and ports
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;
    localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
    localparam int unsigned NUM_PORTS   = 6;
    localparam int unsigned PORT_W      = 8;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RRS_HELD    = 3'b000,
        RRS_COUNT   = 3'b001,
        RRS_FETCH_L = 3'b010,
        RRS_FETCH_H = 3'b011,
        RRS_RUN     = 3'b100
    } rrs_state_t;

endpackage

// ==== rtl/rrs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - On pin release timer 3 loads FF counting osc/16, timer 4 loads 07.
// - Internal reset stays active until timer 4 overflows.
// - Leaving reset enables only the main oscillator in ordinary mode.
// - Leaving reset returns the sub-clock pins to port 5 bits 0 and 1.
// - Execution starts at the vector, high byte FFFF, low byte FFFE.
// - The timers keep counting after internal reset ends.
// - A stop in ordinary mode freezes every I/O port at its last state.
// - After reset every I/O port is turned to input, pins high-impedance.
// - Ordinary mode runs the core clock at main oscillator divided by 2.
module rrs_sequencer
    import rrs_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // External reset pin
    input  wire logic        reset_pin_n,
    // Core control
    input  wire logic        stop_instruction,
    input  wire logic [7:0]  vec_rdata,
    // Core status
    output logic             core_rst,
    output logic [15:0]      vec_addr,
    output logic             vec_rd,
    output logic [15:0]      start_pc,
    output logic             start_valid,
    // Clock and port control
    output logic             main_osc_en,
    output logic             sub_osc_en,
    output logic             low_speed_mode,
    output logic             sub_pins_as_port,
    output logic             phi_en,
    output logic             ports_hold,
    output logic             ports_to_input,
    // Timer view
    output logic [7:0]       timer3_count,
    output logic [7:0]       timer4_count
);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic       sync1_q, sync2_q;
    logic       pin_hi;

    // Two flops; only the second is used
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= reset_pin_n;
            sync2_q <= sync1_q;
        end
    end
    assign pin_hi = sync2_q;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    rrs_state_t st_q, st_d;
    logic [3:0] pre_q, pre_d;
    logic [7:0] lo_q, lo_d;
    logic [15:0] pc_q, pc_d;
    logic       phi_q, phi_d;
    logic       stop_q, stop_d;
    logic       hold;
    logic       t3_tick, t3_ovf, t4_ovf;

    // Timers held while the pin reads low
    assign hold    = !pin_hi;
    assign t3_tick = (pre_q == PRESCALE_LAST);  // osc/16

    rrs_timer8 u_t3 (
        .ref_clk (ref_clk),
        .load    (hold),
        .preset  (T3_PRESET),
        .tick    (t3_tick),
        .ovf     (t3_ovf),
        .count   (timer3_count)
    );

    // Timer 4 counts timer 3 wraps
    rrs_timer8 u_t4 (
        .ref_clk (ref_clk),
        .load    (hold),
        .preset  (T4_PRESET),
        .tick    (t3_ovf),
        .ovf     (t4_ovf),
        .count   (timer4_count)
    );

    // Next state and data
    always_comb begin
        st_d   = st_q;
        lo_d   = lo_q;
        pc_d   = pc_q;
        pre_d  = hold ? 4'h0 : pre_q + 4'h1;  // free-running
        phi_d  = (st_q == RRS_RUN) ? !phi_q : 1'b0;  // osc/2
        stop_d = stop_q;
        if (hold) begin
            st_d   = RRS_HELD;
            stop_d = 1'b0;
        end else begin
            case (st_q)
                RRS_HELD:    st_d = RRS_COUNT;
                RRS_COUNT: begin
                    if (t4_ovf) begin
                        st_d = RRS_FETCH_L;
                    end
                end
                RRS_FETCH_L: begin
                    lo_d = vec_rdata;
                    st_d = RRS_FETCH_H;
                end
                RRS_FETCH_H: begin
                    pc_d = {vec_rdata, lo_q};
                    st_d = RRS_RUN;
                end
                RRS_RUN: begin
                    if (stop_instruction) begin
                        stop_d = 1'b1;
                    end
                end
                default:     st_d = RRS_HELD;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q   <= RRS_HELD;
            pre_q  <= 4'h0;
            lo_q   <= 8'h00;
            pc_q   <= 16'h0000;
            phi_q  <= 1'b0;
            stop_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            pre_q  <= pre_d;
            lo_q   <= lo_d;
            pc_q   <= pc_d;
            phi_q  <= phi_d;
            stop_q <= stop_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Internal reset spans held, counting and vector fetch
    assign core_rst    = (st_q != RRS_RUN);
    assign vec_rd      = (st_q == RRS_FETCH_L) || (st_q == RRS_FETCH_H);
    assign vec_addr    = (st_q == RRS_FETCH_H) ? VEC_HI_ADDR
                                               : VEC_LO_ADDR;
    assign start_pc    = pc_q;
    assign start_valid = (st_q == RRS_RUN);
    // Stop kills every oscillator; otherwise main only
    assign main_osc_en      = !stop_q;
    assign sub_osc_en       = 1'b0;
    assign low_speed_mode   = 1'b0;
    // No sub-clock select lives here, so the pins stay port bits
    assign sub_pins_as_port = 1'b1;
    assign phi_en           = phi_q && !stop_q;
    assign ports_hold       = stop_q;
    assign ports_to_input   = core_rst;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // First step out of held: the synchronised pin has just gone high
    sequence s_pin_rise;
        (st_q == RRS_HELD && !hold) ##1 (st_q == RRS_COUNT);
    endsequence

    property p_release_preset;
        @(posedge ref_clk) disable iff (srst)
        $rose(pin_hi) |-> timer3_count == T3_PRESET
            && timer4_count == T4_PRESET;
    endproperty
    a_release_preset: assert property (p_release_preset)
        else $error("timers not preset at pin release");

    property p_rst_until_ovf;
        @(posedge ref_clk) disable iff (srst)
        (st_q == RRS_COUNT && !t4_ovf && !hold) |=> core_rst;
    endproperty
    a_rst_until_ovf: assert property (p_rst_until_ovf)
        else $error("internal reset ended before timer 4 overflow");

    property p_vector;
        @(posedge ref_clk) disable iff (srst)
        (st_q == RRS_FETCH_L && !hold) ##1 (st_q == RRS_FETCH_H && !hold)
        |=> start_pc == {$past(vec_rdata), $past(vec_rdata, 2)};
    endproperty
    a_vector: assert property (p_vector)
        else $error("start address not built from vector bytes");

    property p_hold_in_reset;
        @(posedge ref_clk) disable iff (srst)
        hold |=> core_rst && ports_to_input && pre_q == 4'h0;
    endproperty
    a_hold_in_reset: assert property (p_hold_in_reset)
        else $error("block not held while pin low");

    property p_keep_counting;
        @(posedge ref_clk) disable iff (srst)
        (st_q == RRS_RUN && !hold) ##1 !hold |-> pre_q == $past(pre_q) + 4'h1;
    endproperty
    a_keep_counting: assert property (p_keep_counting)
        else $error("prescaler stopped after release");

    property p_phi_div2;
        @(posedge ref_clk) disable iff (srst)
        (st_q == RRS_RUN && !hold)[*2] |-> phi_q != $past(phi_q);
    endproperty
    a_phi_div2: assert property (p_phi_div2)
        else $error("core clock not osc/2");

    property p_stop_hold;
        @(posedge ref_clk) disable iff (srst)
        (st_q == RRS_RUN && stop_instruction && !hold)
        |=> ports_hold && !main_osc_en;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("ports not frozen on stop");

    property p_ordinary;
        @(posedge ref_clk) disable iff (srst)
        $fell(core_rst) |-> !sub_osc_en && !low_speed_mode && main_osc_en
            && sub_pins_as_port;
    endproperty
    a_ordinary: assert property (p_ordinary)
        else $error("not ordinary mode at release");

    property p_sync;
        @(posedge ref_clk) disable iff (srst)
        s_pin_rise |-> $past(reset_pin_n, 3) && $past(sync1_q, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("count started without synchronised pin");

endmodule

`default_nettype wire

// ==== rtl/rrs_timer8.sv ====
`timescale 1ns/1ps
`default_nettype none

// Down counter that reloads on underflow and flags the wrap
module rrs_timer8
    import rrs_pkg::*;
(
    // Clock and hold
    input  wire logic       ref_clk,
    input  wire logic       load,
    // Count control
    input  wire logic [7:0] preset,
    input  wire logic       tick,
    // Status
    output logic            ovf,
    output logic [7:0]      count
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // Next value; reload keeps counting after wrap
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = preset;
        end else if (tick) begin
            cnt_d = (cnt_q == T_ZERO) ? preset : cnt_q - 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        cnt_q <= cnt_d;
    end

    assign ovf   = tick && !load && (cnt_q == T_ZERO);
    assign count = cnt_q;

endmodule

`default_nettype wire

// ==== testbench/rrs_reset_src.sv ====
`timescale 1ns/1ps
`default_nettype none

// Reset source: pulls the pin low for a requested time
module rrs_reset_src
    import rrs_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // Request
    input  wire logic        go,
    input  wire logic [15:0] len,
    // Pin
    output logic             reset_pin_n
);
    int unsigned left = RST_MIN_LOW_CYC;

    // Short requests are stretched, never under the minimum low time
    always @(posedge ref_clk) begin
        if (go) begin
            left <= (len < RST_MIN_LOW_CYC) ? RST_MIN_LOW_CYC : len;
        end else if (left != 0) begin
            left <= left - 1;
        end
    end

    // Pin is driven at all times, so no floating level to model
    assign reset_pin_n = (left == 0);
endmodule

`default_nettype wire

// ==== testbench/test_reset_release_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_reset_release_sequencer
    import rrs_pkg::*;
;
    logic        ref_clk, srst, reset_pin_n, stop_instruction, go;
    logic [7:0]  vec_rdata, lo_b, hi_b, timer3_count, timer4_count;
    logic [15:0] len, vec_addr, start_pc;
    logic        core_rst, vec_rd, start_valid, main_osc_en, sub_osc_en;
    logic        low_speed_mode, sub_pins_as_port, phi_en, ports_hold;
    logic        ports_to_input;
    int          n_errors, checks;

    // ------------------------------------------------------------
    // Clock, partner and design
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    rrs_reset_src SRC (.ref_clk, .go, .len, .reset_pin_n);

    rrs_sequencer DUT (.ref_clk, .srst, .reset_pin_n, .stop_instruction,
        .vec_rdata, .core_rst, .vec_addr, .vec_rd, .start_pc, .start_valid,
        .main_osc_en, .sub_osc_en, .low_speed_mode, .sub_pins_as_port,
        .phi_en, .ports_hold, .ports_to_input, .timer3_count, .timer4_count);

    // Vector memory answers in the same cycle, as the core expects
    assign vec_rdata = (vec_addr === VEC_HI_ADDR) ? hi_b : lo_b;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] exp_pc(input logic [7:0] hi,
                                           input logic [7:0] lo);
        return {hi, lo};
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out();
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask

    // Pin low; a stop request here must be ignored
    task automatic hold_low(input logic stop_in);
        int n;
        @(posedge ref_clk);
        go <= 1'b1;
        len <= 16'(RST_MIN_LOW_CYC + $urandom_range(300));
        stop_instruction <= stop_in;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (100) @(posedge ref_clk);
        #1;
        check(core_rst, 1'b1);
        check(timer3_count, T3_PRESET);
        check(timer4_count, T4_PRESET);
        check(ports_to_input, 1'b1);
        check(sub_pins_as_port, 1'b1);
        check(ports_hold, 1'b0);
        check(phi_en, 1'b0);
        @(posedge ref_clk);
        stop_instruction <= 1'b0;
        for (n = 0; reset_pin_n !== 1'b1; n++) begin
            if (n > 1000) timed_out();
            @(posedge ref_clk);
        end
    endtask

    // Full release delay, vector fetch and state after reset
    task automatic release_run();
        int n;
        logic [15:0] seen_q[$];
        logic p;
        logic [15:0] t;
        for (n = 0; core_rst !== 1'b0; n++) begin
            if (n > 34000) timed_out();
            @(posedge ref_clk);
            #1;
            if (vec_rd === 1'b1) seen_q.push_back(vec_addr);
        end
        check(16'(n > 32750 && n < 32800), 16'h0001);
        check(16'(seen_q.size()), 16'h0002);
        check(seen_q[0], VEC_LO_ADDR);
        check(seen_q[1], VEC_HI_ADDR);
        check(start_valid, 1'b1);
        check(start_pc, exp_pc(hi_b, lo_b));
        check(main_osc_en, 1'b1);
        check(sub_osc_en, 1'b0);
        check(low_speed_mode, 1'b0);
        check(sub_pins_as_port, 1'b1);
        repeat (4) begin
            p = phi_en;
            @(posedge ref_clk);
            #1;
            check(phi_en ^ p, 1'b1);
        end
        t = {timer4_count, timer3_count};
        repeat (40) @(posedge ref_clk);
        #1;
        check(16'({timer4_count, timer3_count} != t), 16'h0001);
    endtask

    // Stop in ordinary mode freezes the ports
    task automatic stop_check();
        @(posedge ref_clk);
        stop_instruction <= 1'b1;
        @(posedge ref_clk);
        stop_instruction <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        check(ports_hold, 1'b1);
        check(main_osc_en, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Main sequence: full run, aborted count, full run
    // ------------------------------------------------------------
    initial begin
        srst = 1'b1;
        stop_instruction = 1'b0;
        go = 1'b0;
        len = 16'h0000;
        lo_b = 8'h00;
        hi_b = 8'h00;
        n_errors = 0;
        checks = 0;
        void'($urandom(32'h0b6fe75b));
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            lo_b <= (r == 0) ? 8'h00 : 8'($urandom);
            hi_b <= (r == 0) ? 8'hFF : 8'($urandom);
            hold_low(r == 0);
            if (r == 1) begin
                repeat ($urandom_range(4000, 100)) @(posedge ref_clk);
                #1;
                check(core_rst, 1'b1);
                check(vec_rd, 1'b0);
            end else begin
                release_run();
                stop_check();
            end
            $display("test %0d done", r);
        end
        wrap_up();
    end
endmodule

`default_nettype wire
